/* rtl/tbdo_map.vh */
`ifndef TBDO_MAP_VH
`define TBDO_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
// Printed offset 0x36 is not a multiple of four: index kept, byte address is index * 4
`define TBDO_CTRL_INDEX 12'h036
`define TBDO_CTRL_ADDR 12'h0D8
`define TBDO_STAT_ADDR 12'h0E0
`define TBDO_MASK_ADDR 12'h0E4
`define TBDO_CFG_ADDR 12'h0E8

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TBDO_PULSE_EN_BIT 7
`define TBDO_PULSE_RATE_HI 6
`define TBDO_PULSE_RATE_LO 5
`define TBDO_ZERO_BIT 4
`define TBDO_TICK_EN_BIT 3
`define TBDO_TICK_RATE_HI 2
`define TBDO_TICK_RATE_LO 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TBDO_CTRL_RESET 8'h00
`define TBDO_MASK_RESET 1'b0
`define TBDO_PRESCALE_RESET 1'b0

// ----------------------------------------
// Divider sizing
// ----------------------------------------
`define TBDO_DIV_WIDTH 24

`endif

/* rtl/tbdo_divider.v */
`include "tbdo_map.vh"

// ----------------------------------------
// Free-running divider of the high-frequency clock
// ----------------------------------------
module tbdo_divider #(
	parameter WIDTH = `TBDO_DIV_WIDTH
) (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire ce, // clock enable
	output reg [WIDTH-1:0] div_q // divider taps
);

	// Never cleared by software; only reset touches it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= {WIDTH{1'b0}};
		else if (ce)
			div_q <= div_q + {{(WIDTH-1){1'b0}}, 1'b1};
	end

endmodule // tbdo_divider

/* rtl/tbdo_tap_edge.v */
`include "tbdo_map.vh"

// ----------------------------------------
// Tap selection with falling-edge detect
// ----------------------------------------
module tbdo_tap_edge #(
	parameter WIDTH = `TBDO_DIV_WIDTH
) (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire ce, // clock enable
	input wire [WIDTH-1:0] taps, // divider taps
	input wire [4:0] sel, // tap index, bit sel toggles at fc/2^(sel+1)
	output wire level, // selected tap level
	output wire fall // one-cycle pulse on falling edge
);

	reg prev_q;

	assign level = taps[sel];
	assign fall = ce & prev_q & ~level;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_q <= 1'b0;
		else if (ce)
			prev_q <= level;
	end

endmodule // tbdo_tap_edge

/* rtl/tbdo_top.v */
`include "tbdo_map.vh"

module tbdo_top #(
	parameter DIV_WIDTH = `TBDO_DIV_WIDTH
) (
	input wire pclk, // APB clock, stands in for the high-frequency clock
	input wire presetn, // async reset, active low
	input wire ce, // clock enable, freezes all state
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output wire [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error on unmapped address
	output wire irq, // level interrupt
	output wire tick_interrupt, // one-cycle periodic tick request
	output reg buzzer_pulse_out_n // active-low pulse pin
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] ctrl_q;
	reg prescale_select_q;
	reg stat_q;
	reg mask_q;
	reg [31:0] rdata_q;
	reg [31:0] rdata_d;
	reg err_d;
	reg err_q;
	reg [4:0] tick_sel;
	reg [4:0] pulse_sel;

	wire [DIV_WIDTH-1:0] div_taps;
	wire tick_fall;
	wire pulse_level;
	wire tick_enable;
	wire pulse_out_enable;
	wire [2:0] tick_rate_select;
	wire [1:0] pulse_rate_select;
	wire wr_en;
	wire rd_en;

	assign tick_enable = ctrl_q[`TBDO_TICK_EN_BIT];
	assign pulse_out_enable = ctrl_q[`TBDO_PULSE_EN_BIT];
	assign tick_rate_select = ctrl_q[`TBDO_TICK_RATE_HI:`TBDO_TICK_RATE_LO];
	assign pulse_rate_select = ctrl_q[`TBDO_PULSE_RATE_HI:`TBDO_PULSE_RATE_LO];

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	assign pready = 1'b1;
	assign wr_en = ce & psel & penable & pwrite;
	assign rd_en = ce & psel & ~penable & ~pwrite;
	assign prdata = rdata_q;
	assign pslverr = psel & penable & err_q;

	// Read data latched in setup so it comes from a flip-flop in access
	always @*
	begin
		rdata_d = 32'h00000000;
		err_d = 1'b0;
		case (paddr)
			`TBDO_CTRL_ADDR: rdata_d = {24'h000000, ctrl_q};
			`TBDO_STAT_ADDR: rdata_d = {31'h00000000, stat_q};
			`TBDO_MASK_ADDR: rdata_d = {31'h00000000, mask_q};
			`TBDO_CFG_ADDR: rdata_d = {31'h00000000, prescale_select_q};
			default: err_d = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
		end
		else if (ce && psel && !penable)
		begin
			rdata_q <= rd_en ? rdata_d : 32'h00000000;
			err_q <= err_d;
		end
	end

	// ----------------------------------------
	// Control, configuration and mask
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `TBDO_CTRL_RESET;
			prescale_select_q <= `TBDO_PRESCALE_RESET;
			mask_q <= `TBDO_MASK_RESET;
		end
		else if (wr_en)
		begin
			case (paddr)
				// Bit 4 forced to zero whatever software writes; rate and enable
				// land together so one write may set both
				`TBDO_CTRL_ADDR: ctrl_q <= pwdata[7:0] & 8'hEF;
				`TBDO_CFG_ADDR: prescale_select_q <= pwdata[0];
				`TBDO_MASK_ADDR: mask_q <= pwdata[0];
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	// ----------------------------------------
	// Rate decode
	// ----------------------------------------
	// Tap index n toggles at fc/2^(n+1), so a divide exponent e uses tap e-1
	always @*
	begin
		case (tick_rate_select)
			3'h0: tick_sel = 5'd22;
			3'h1: tick_sel = 5'd20;
			3'h2: tick_sel = 5'd15;
			3'h3: tick_sel = 5'd13;
			3'h4: tick_sel = 5'd12;
			3'h5: tick_sel = 5'd11;
			3'h6: tick_sel = 5'd10;
			3'h7: tick_sel = 5'd8;
			default: tick_sel = 5'd22;
		endcase
		if (prescale_select_q)
			tick_sel = tick_sel + 5'd1;
	end

	always @*
	begin
		case (pulse_rate_select)
			2'h0: pulse_sel = 5'd12;
			2'h1: pulse_sel = 5'd11;
			2'h2: pulse_sel = 5'd10;
			2'h3: pulse_sel = 5'd9;
			default: pulse_sel = 5'd12;
		endcase
		if (prescale_select_q)
			pulse_sel = pulse_sel + 5'd1;
	end

	// ----------------------------------------
	// Shared divider and taps
	// ----------------------------------------
	tbdo_divider #(
		.WIDTH(DIV_WIDTH)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.div_q(div_taps)
	);

	tbdo_tap_edge #(
		.WIDTH(DIV_WIDTH)
	) u_tick_tap (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.taps(div_taps),
		.sel(tick_sel),
		.level(),
		.fall(tick_fall)
	);

	tbdo_tap_edge #(
		.WIDTH(DIV_WIDTH)
	) u_pulse_tap (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.taps(div_taps),
		.sel(pulse_sel),
		.level(pulse_level),
		.fall()
	);

	// ----------------------------------------
	// Tick request and interrupt status
	// ----------------------------------------
	// Divider keeps running while disabled, so the first tick may come early
	assign tick_interrupt = tick_enable & tick_fall;
	assign irq = stat_q & mask_q;

	// Set wins over a write-one clear in the same cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_q <= 1'b0;
		else if (ce)
		begin
			if (tick_interrupt)
				stat_q <= 1'b1;
			else if (wr_en && paddr == `TBDO_STAT_ADDR && pwdata[0])
				stat_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Pulse pin
	// ----------------------------------------
	// Square tap gives exact half duty; pin idles high when disabled
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			buzzer_pulse_out_n <= 1'b1;
		else if (ce)
			buzzer_pulse_out_n <= pulse_out_enable ? pulse_level : 1'b1;
	end

endmodule // tbdo_top

/* tb/tbdo_props.sv */
`include "tbdo_map.vh"
module tbdo_props (
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic ce, // enable
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // dir
	input wire logic [11:0] paddr, // addr
	input wire logic [31:0] pwdata, // wdata
	input wire logic [31:0] prdata, // rdata
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic irq, // irq
	input wire logic tick_interrupt, // tick
	input wire logic buzzer_pulse_out_n // pin
);
	// ----------------
	// Checks
	// ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic hit = paddr == `TBDO_CTRL_ADDR || paddr == `TBDO_STAT_ADDR
		|| paddr == `TBDO_MASK_ADDR || paddr == `TBDO_CFG_ADDR;
	sequence s_quiet;
		!tick_interrupt [*8];
	endsequence
	a_ready_high: assert property (pready) else $error("ready low");
	a_tick_gap: assert property (tick_interrupt |=> s_quiet) else $error("tick gap");
	a_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no error");
	a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("false error");
	a_err_idle: assert property (!acc |-> !pslverr) else $error("stray error");
	a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	a_ctrl_read: assert property (acc && !pwrite && paddr == `TBDO_CTRL_ADDR
		|-> prdata[31:8] == 24'h0 && !prdata[4]) else $error("ctrl layout");
	a_reset_idle: assert property ($rose(presetn)
		|-> buzzer_pulse_out_n && !irq && !tick_interrupt) else $error("reset state");
endmodule // tbdo_props
bind tbdo_top tbdo_props u_tbdo_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .tick_interrupt(tick_interrupt),
	.buzzer_pulse_out_n(buzzer_pulse_out_n));

/* tb/tbdo_buzzer.sv */
// ----------------
// Buzzer phase timer
// ----------------
module tbdo_buzzer (
	input wire logic pclk, // clock
	input wire logic pin_n, // pin
	output int hi_len, // high cycles
	output int lo_len // low cycles
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	logic last = 1'b1;
	always @(posedge pclk)
	begin
		if (pin_n !== last)
		begin
			if (last) hi_len <= cnt;
			else lo_len <= cnt;
			cnt <= 1;
		end
		else cnt <= cnt + 1;
		last <= pin_n;
	end
endmodule // tbdo_buzzer

/* tb/tbdo_top_bench.sv */
`include "tbdo_map.vh"
module tbdo_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r, cur;
	logic pready, pslverr, irq, tick_interrupt, buzzer_pulse_out_n;
	int failures = 0, cmp_count = 0, n, hi_len, lo_len, et, ep, c;
	tbdo_top u_tbdo_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .tick_interrupt(tick_interrupt),
		.buzzer_pulse_out_n(buzzer_pulse_out_n));
	tbdo_buzzer u_tbdo_buzzer (.pclk(pclk), .pin_n(buzzer_pulse_out_n), .hi_len(hi_len),
		.lo_len(lo_len));
	// ----------------
	// Tasks
	// ----------------
	initial forever #12.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge so a following call never re-raises psel in the same step
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	task automatic gap(output int k);
		k = 0;
		do @(negedge pclk); while (tick_interrupt !== 1'b1);
		do
		begin
			@(negedge pclk);
			k++;
		end
		while (tick_interrupt !== 1'b1);
		@(posedge pclk);
	endtask
	task automatic wrap_up;
		$display("compares=%0d errors=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#2000000;
		failures++;
		wrap_up;
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`TBDO_CTRL_ADDR, 32'h0);
		rd(12'h100, 32'h0);
		chk(e, 1'b1);
		cur = 32'hEF;
		apb(1'b1, `TBDO_CTRL_ADDR, cur);
		rd(`TBDO_CTRL_ADDR, 32'hEF);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, `TBDO_CTRL_ADDR, cur & 32'h67);
			if (i == 4) apb(1'b1, `TBDO_CFG_ADDR, 32'h1);
			c = (i > 3) ? 3 : i;
			et = ((c < 3) ? 13 - c : 9) + i / 4;
			ep = 13 - c + i / 4;
			cur = {24'h0, 1'b1, c[1:0], 2'b01, 1'b1, c[1:0]};
			apb(1'b1, `TBDO_CTRL_ADDR, cur);
			gap(n);
			chk(n, 1 << et);
			// Two full periods so both phases are timed after the rate change
			repeat (2 << ep) @(posedge pclk);
			chk(lo_len, 1 << (ep - 1));
			chk(hi_len, 1 << (ep - 1));
		end
		apb(1'b1, `TBDO_CTRL_ADDR, cur & 32'h67);
		repeat (2) @(posedge pclk);
		n = 0;
		repeat (2100) @(negedge pclk) n += tick_interrupt + !buzzer_pulse_out_n;
		@(posedge pclk);
		chk(n, 0);
		rd(`TBDO_STAT_ADDR, 32'h1);
		chk(irq, 1'b0);
		apb(1'b1, `TBDO_MASK_ADDR, 32'h1);
		rd(`TBDO_MASK_ADDR, 32'h1);
		chk(irq, 1'b1);
		apb(1'b1, `TBDO_STAT_ADDR, 32'h1);
		rd(`TBDO_STAT_ADDR, 32'h0);
		chk(irq, 1'b0);
		wrap_up;
	end
endmodule // tbdo_top_bench
